// file: src/msz_core.v
// Measurement statistics and master/zero offset stage with Avalon-MM registers
//
// Register access over Avalon-MM and the address map were left to the implementer.
`timescale 1ns/100ps
`include "msz_defines.vh"
// What this block does
// RULE_01 - Each enabled statistics slot produces a minimum, a maximum and max minus min.
// RULE_02 - Window depth is a power of two from 2 to 8192 over the newest samples.
// RULE_03 - Unbounded depth covers every sample since the last restart.
// RULE_04 - Removing a statistics source deletes the slot and its three outputs.
// RULE_05 - A restart for one or all slots clears min and max, restarting at the next sample.
// RULE_06 - The active-statistics query shows only slots created by the source command.
// RULE_07 - Ten zero slots may each attach to any internal signal.
// RULE_08 - A slot target is accepted only within -2147.0 to +2147.0 mm.
// RULE_09 - Defining a slot with removal clears its definition and frees it.
// RULE_10 - Set activates, reset deactivates and undoes the offset, all applies to every slot.
// RULE_11 - A target of zero makes the signal read zero at activation.
// RULE_12 - A status query reports each of the ten slots with its signal and state or empty; the status register holds only the active and defined masks.
// RULE_13 - The defined-slots query lists every defined slot or none.
// RULE_14 - The external selection picks all, none or a list of defined slots.
// RULE_15 - The trigger source is either commands only or the multifunction input.
// RULE_16 - Activation captures the raw value, then output is raw minus captured plus target.
// RULE_17 - One rising edge on the multifunction input sets all externally selected slots.
module msz_core (
  // Clock and reset
  input wire i_clock,
  input wire i_rst_b,
  // Avalon-MM slave
  input wire [7:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  output reg [31:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  // Sample stream, signed nm per signal
  input wire i_sample_valid,
  input wire [`MSZ_NSIG*`MSZ_W-1:0] i_sample_bus,
  // External trigger pin
  input wire i_multifunction_input_one,
  // Statistics results
  output wire [`MSZ_NSTAT*`MSZ_W-1:0] o_stat_min,
  output wire [`MSZ_NSTAT*`MSZ_W-1:0] o_stat_max,
  output wire [`MSZ_NSTAT*`MSZ_W-1:0] o_stat_peak,
  output wire [`MSZ_NSTAT-1:0] o_stat_valid,
  // Zeroed results
  output reg [`MSZ_NZERO*`MSZ_W-1:0] o_zero_value,
  output wire [`MSZ_NZERO-1:0] o_zero_active
);
  function [`MSZ_W-1:0] sel_sig;
    input [`MSZ_NSIG*`MSZ_W-1:0] bus;
    input [2:0] idx;
    begin
      sel_sig = bus[idx*`MSZ_W +: `MSZ_W];
    end
  endfunction

  function in_range;
    input [`MSZ_W-1:0] v;
    begin
      in_range = ($signed(v) <= $signed(`MSZ_TARGET_MAX)) &&
        ($signed(v) >= $signed(`MSZ_TARGET_MIN));
    end
  endfunction

  // Write strobe for one offset in the completing cycle
  function wr_hit;
    input go;
    input [7:0] addr;
    input [7:0] off;
    begin
      wr_hit = go && (addr == off);
    end
  endfunction

  // Offset applied to an active slot; wraps like the raw value
  function [`MSZ_W-1:0] zero_apply;
    input [`MSZ_W-1:0] raw;
    input [`MSZ_W-1:0] cap;
    input [`MSZ_W-1:0] tgt;
    begin
      zero_apply = raw - cap + tgt;
    end
  endfunction

  integer i;
  integer j;
  integer k;
  genvar g;

  // Bus handshake: one wait cycle, then the access completes
  // A request held past completion starts a fresh wait cycle
  reg ack_r;
  wire acc = i_avs_read | i_avs_write;
  wire wr_go = i_avs_write & ack_r;
  wire [31:0] wd = i_avs_writedata;
  assign o_avs_waitrequest = acc & ~ack_r;

  always @(posedge i_clock) begin
    if (!i_rst_b)
      ack_r <= 1'b0;
    else
      ack_r <= acc & ~ack_r;
  end

  // Statistics configuration
  reg [`MSZ_NSTAT-1:0] st_en_r;
  reg [`MSZ_NSTAT-1:0] st_unb_r;
  reg [`MSZ_NSTAT-1:0] st_rst_r;
  reg [2:0] st_src_r [0:`MSZ_NSTAT-1];
  reg [3:0] st_lg_r [0:`MSZ_NSTAT-1];
  reg [1:0] st_sel_r;
  reg err_r;

  // Zero slot storage
  reg [`MSZ_NZERO-1:0] zd_r;
  reg [`MSZ_NZERO-1:0] za_r;
  reg [2:0] zs_r [0:`MSZ_NZERO-1];
  reg [`MSZ_W-1:0] zt_r [0:`MSZ_NZERO-1];
  reg [`MSZ_W-1:0] zc_r [0:`MSZ_NZERO-1];
  reg [`MSZ_W-1:0] stage_r;
  reg [`MSZ_NZERO-1:0] ext_sel_r;
  reg ext_src_r;
  reg [3:0] z_sel_r;
  assign o_zero_active = za_r;

  // Raw value feeding each zero slot
  wire [`MSZ_W-1:0] z_raw [0:`MSZ_NZERO-1];
  generate
    for (g = 0; g < `MSZ_NZERO; g = g + 1) begin : gen_zraw
      assign z_raw[g] = sel_sig(i_sample_bus, zs_r[g]);
    end
  endgenerate

  // Pin synchroniser and edge detect
  reg mfi_s1_r;
  reg mfi_s2_r;
  reg mfi_d_r;
  always @(posedge i_clock) begin
    if (!i_rst_b) begin
      mfi_s1_r <= 1'b0;
      mfi_s2_r <= 1'b0;
      mfi_d_r <= 1'b0;
    end else begin
      mfi_s1_r <= i_multifunction_input_one;
      mfi_s2_r <= mfi_s1_r;
      mfi_d_r <= mfi_s2_r;
    end
  end
  // RULE_15 pin only counts when selected
  // RULE_17 one edge, one set
  wire ext_trig = ext_src_r & mfi_s2_r & ~mfi_d_r;

  // Write decode
  wire w_stcfg = wr_hit(wr_go, i_avs_address, `MSZ_OFF_STAT_CFG);
  wire w_strst = wr_hit(wr_go, i_avs_address, `MSZ_OFF_STAT_RESTART);
  wire w_zdef = wr_hit(wr_go, i_avs_address, `MSZ_OFF_ZERO_DEFINE);
  wire w_zcmd = wr_hit(wr_go, i_avs_address, `MSZ_OFF_ZERO_CMD);
  wire w_err = wr_hit(wr_go, i_avs_address, `MSZ_OFF_ERROR);
  wire w_stsel = wr_hit(wr_go, i_avs_address, `MSZ_OFF_STAT_SEL);
  wire w_ztgt = wr_hit(wr_go, i_avs_address, `MSZ_OFF_ZERO_TARGET);
  wire w_zsel = wr_hit(wr_go, i_avs_address, `MSZ_OFF_ZERO_SEL);
  wire w_ext = wr_hit(wr_go, i_avs_address, `MSZ_OFF_EXT_CFG);
  wire [1:0] w_sslot = wd[`MSZ_F_SLOT_LO +: 2];
  wire [3:0] w_zslot = wd[`MSZ_F_SLOT_LO +: 4];
  wire [3:0] w_lg = wd[`MSZ_F_LG_LO +: 4];
  wire lg_bad = wd[`MSZ_F_EN] && !wd[`MSZ_F_UNB] &&
    (w_lg < `MSZ_LG_MIN || w_lg > `MSZ_LG_MAX);
  wire zslot_bad = w_zslot >= `MSZ_NZERO;
  // RULE_08 reject out-of-range target
  wire tgt_bad = !wd[`MSZ_F_RM] && !in_range(stage_r);
  wire bad_req = (w_stcfg && lg_bad) || (w_zdef && (zslot_bad || tgt_bad));
  // RULE_10 all applies to every defined slot
  wire [`MSZ_NZERO-1:0] cmd_mask = wd[`MSZ_F_ALL] ? `MSZ_ZERO_ALL : wd[`MSZ_NZERO-1:0];
  // Set and reset requests before the slot mask
  wire z_set_cmd = w_zcmd && wd[`MSZ_F_SET];
  wire z_rst_cmd = w_zcmd && wd[`MSZ_F_RST];

  always @(posedge i_clock) begin
    if (!i_rst_b) begin
      st_en_r <= {`MSZ_NSTAT{1'b0}};
      st_unb_r <= {`MSZ_NSTAT{1'b0}};
      st_rst_r <= {`MSZ_NSTAT{1'b0}};
      for (j = 0; j < `MSZ_NSTAT; j = j + 1) begin
        st_src_r[j] <= 3'h0;
        st_lg_r[j] <= `MSZ_LG_MIN;
      end
    end else begin
      st_rst_r <= {`MSZ_NSTAT{1'b0}};
      if (w_stcfg && !lg_bad) begin
        // RULE_04 enable low removes the slot
        st_en_r[w_sslot] <= wd[`MSZ_F_EN];
        st_unb_r[w_sslot] <= wd[`MSZ_F_UNB];
        st_src_r[w_sslot] <= wd[`MSZ_F_SRC_LO +: 3];
        st_lg_r[w_sslot] <= w_lg;
        st_rst_r[w_sslot] <= 1'b1;
      end
      // RULE_05 restart one or all
      if (w_strst)
        st_rst_r <= wd[`MSZ_F_RESTART_ALL] ? {`MSZ_NSTAT{1'b1}} : wd[`MSZ_NSTAT-1:0];
    end
  end

  // Error flag: a new fault wins over a clear
  always @(posedge i_clock) begin
    if (!i_rst_b)
      err_r <= 1'b0;
    else if (bad_req)
      err_r <= 1'b1;
    else if (w_err && wd[0])
      err_r <= 1'b0;
  end

  // Selectors, staged target and external trigger setup
  always @(posedge i_clock) begin
    if (!i_rst_b) begin
      st_sel_r <= 2'h0;
      stage_r <= {`MSZ_W{1'b0}};
      z_sel_r <= 4'h0;
      ext_sel_r <= {`MSZ_NZERO{1'b0}};
      ext_src_r <= 1'b0;
    end else begin
      if (w_stsel)
        st_sel_r <= wd[1:0];
      // Only staged here; a define takes it into a slot
      if (w_ztgt)
        stage_r <= wd;
      if (w_zsel)
        z_sel_r <= wd[3:0];
      // RULE_14 all, none or a list
      if (w_ext) begin
        ext_sel_r <= wd[`MSZ_NZERO-1:0];
        ext_src_r <= wd[`MSZ_F_EXT_SRC];
      end
    end
  end

  // Zero slot control; removal beats set, set beats reset
  always @(posedge i_clock) begin
    if (!i_rst_b) begin
      zd_r <= {`MSZ_NZERO{1'b0}};
      za_r <= {`MSZ_NZERO{1'b0}};
      for (i = 0; i < `MSZ_NZERO; i = i + 1) begin
        zs_r[i] <= 3'h0;
        zt_r[i] <= {`MSZ_W{1'b0}};
        zc_r[i] <= {`MSZ_W{1'b0}};
      end
    end else begin
      for (i = 0; i < `MSZ_NZERO; i = i + 1) begin
        if (w_zdef && !zslot_bad && w_zslot == i[3:0]) begin
          // RULE_09 removal frees the slot
          if (wd[`MSZ_F_RM]) begin
            zd_r[i] <= 1'b0;
            za_r[i] <= 1'b0;
          // RULE_07 any signal per slot
          end else if (!tgt_bad) begin
            zd_r[i] <= 1'b1;
            za_r[i] <= 1'b0;
            zs_r[i] <= wd[`MSZ_F_SRC_LO +: 3];
            zt_r[i] <= stage_r;
          end
        // RULE_10 set or reset on command
        // RULE_17 external edge sets selected
        end else if (zd_r[i] && ((z_set_cmd && cmd_mask[i]) ||
            (ext_trig && ext_sel_r[i]))) begin
          za_r[i] <= 1'b1;
          // RULE_16 capture raw at activation
          zc_r[i] <= z_raw[i];
        end else if (z_rst_cmd && cmd_mask[i]) begin
          za_r[i] <= 1'b0;
        end
      end
    end
  end

  // Zeroed outputs follow each sample
  always @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_zero_value <= {(`MSZ_NZERO*`MSZ_W){1'b0}};
    end else if (i_sample_valid) begin
      // Offset shows from the sample after activation
      for (k = 0; k < `MSZ_NZERO; k = k + 1) begin
        // RULE_11 zero target reads zero
        // RULE_16 raw minus captured plus target
        if (za_r[k])
          o_zero_value[k*`MSZ_W +: `MSZ_W] <= zero_apply(z_raw[k], zc_r[k], zt_r[k]);
        else
          o_zero_value[k*`MSZ_W +: `MSZ_W] <= z_raw[k];
      end
    end
  end

  // Statistics slots
  generate
    for (g = 0; g < `MSZ_NSTAT; g = g + 1) begin : gen_stat
      msz_stat_slot u_slot (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_enable(st_en_r[g]),
        .i_unbounded(st_unb_r[g]),
        .i_depth_lg(st_lg_r[g]),
        .i_restart(st_rst_r[g]),
        .i_valid(i_sample_valid),
        .i_value(sel_sig(i_sample_bus, st_src_r[g])),
        .o_min(o_stat_min[g*`MSZ_W +: `MSZ_W]),
        .o_max(o_stat_max[g*`MSZ_W +: `MSZ_W]),
        .o_peak(o_stat_peak[g*`MSZ_W +: `MSZ_W]),
        .o_valid(o_stat_valid[g])
      );
    end
  endgenerate

  // Read mux; unmapped offsets read zero
  reg [31:0] rd_nxt;
  wire [3:0] zi = (z_sel_r < `MSZ_NZERO) ? z_sel_r : 4'h0;
  // Readback of the selected slots; statistics config in its written layout, zero info with its source in bits 2:0
  wire [31:0] stat_cfg_rd = {15'h0, st_en_r[st_sel_r], 3'h0, st_unb_r[st_sel_r],
    st_lg_r[st_sel_r], 1'b0, st_src_r[st_sel_r], 2'h0, st_sel_r};
  wire [31:0] zero_info_rd = {22'h0, za_r[zi], zd_r[zi], 5'h0, zs_r[zi]};
  always @* begin
    rd_nxt = 32'h0;
    case (i_avs_address)
      `MSZ_OFF_STAT_CFG: rd_nxt = stat_cfg_rd;
      // RULE_06 only created slots
      `MSZ_OFF_STAT_ACTIVE: rd_nxt = {28'h0, st_en_r};
      `MSZ_OFF_ZERO_TARGET: rd_nxt = stage_r;
      // RULE_12 defined and active per slot
      // RULE_13 defined mask, zero when none
      `MSZ_OFF_ZERO_STATUS: rd_nxt = {6'h0, za_r, 6'h0, zd_r};
      `MSZ_OFF_EXT_CFG: rd_nxt = {15'h0, ext_src_r, 6'h0, ext_sel_r};
      `MSZ_OFF_ERROR: rd_nxt = {31'h0, err_r};
      `MSZ_OFF_STAT_SEL: rd_nxt = {30'h0, st_sel_r};
      `MSZ_OFF_STAT_MIN: rd_nxt = o_stat_min[st_sel_r*`MSZ_W +: `MSZ_W];
      `MSZ_OFF_STAT_MAX: rd_nxt = o_stat_max[st_sel_r*`MSZ_W +: `MSZ_W];
      `MSZ_OFF_STAT_PEAK: rd_nxt = o_stat_peak[st_sel_r*`MSZ_W +: `MSZ_W];
      `MSZ_OFF_ZERO_SEL: rd_nxt = {28'h0, z_sel_r};
      `MSZ_OFF_ZERO_TGT_RD: rd_nxt = zt_r[zi];
      `MSZ_OFF_ZERO_INFO: rd_nxt = zero_info_rd;
      default: rd_nxt = 32'h0;
    endcase
  end

  // Loaded in the wait cycle, so it stands at completion
  always @(posedge i_clock) begin
    if (!i_rst_b)
      o_avs_readdata <= 32'h0;
    else if (i_avs_read && !ack_r)
      o_avs_readdata <= rd_nxt;
  end
endmodule

// file: src/msz_defines.vh
// Constants for the measurement statistics and zeroing block
`ifndef MSZ_DEFINES_VH
`define MSZ_DEFINES_VH
`define MSZ_W 32
`define MSZ_NSIG 8
`define MSZ_NSTAT 4
`define MSZ_NZERO 10
`define MSZ_ZERO_ALL 10'h3FF
`define MSZ_LG_MIN 4'h1
`define MSZ_LG_MAX 4'hD
`define MSZ_CNT_W 14
// Target range +-2147.0 mm in nm
`define MSZ_TARGET_MAX 32'h7FF89EC0
`define MSZ_TARGET_MIN 32'h80076140
// Register byte offsets
`define MSZ_OFF_STAT_CFG 8'h00
`define MSZ_OFF_STAT_RESTART 8'h04
`define MSZ_OFF_STAT_ACTIVE 8'h08
`define MSZ_OFF_ZERO_TARGET 8'h0C
`define MSZ_OFF_ZERO_DEFINE 8'h10
`define MSZ_OFF_ZERO_CMD 8'h14
`define MSZ_OFF_ZERO_STATUS 8'h18
`define MSZ_OFF_EXT_CFG 8'h1C
`define MSZ_OFF_ERROR 8'h20
`define MSZ_OFF_STAT_SEL 8'h24
`define MSZ_OFF_STAT_MIN 8'h28
`define MSZ_OFF_STAT_MAX 8'h2C
`define MSZ_OFF_STAT_PEAK 8'h30
`define MSZ_OFF_ZERO_SEL 8'h34
`define MSZ_OFF_ZERO_TGT_RD 8'h38
`define MSZ_OFF_ZERO_INFO 8'h3C
// Field positions
`define MSZ_F_SLOT_LO 0
`define MSZ_F_SRC_LO 4
`define MSZ_F_LG_LO 8
`define MSZ_F_UNB 12
`define MSZ_F_EN 16
`define MSZ_F_RM 8
`define MSZ_F_ALL 16
`define MSZ_F_SET 17
`define MSZ_F_RST 18
`define MSZ_F_EXT_SRC 16
`define MSZ_F_RESTART_ALL 31
`endif

// file: src/msz_stat_slot.v
// One statistics slot: windowed or unbounded min, max and peak-to-peak
`timescale 1ns/100ps
`include "msz_defines.vh"
module msz_stat_slot (
  // Clock and reset
  input wire i_clock,
  input wire i_rst_b,
  // Configuration
  input wire i_enable,
  input wire i_unbounded,
  input wire [3:0] i_depth_lg,
  input wire i_restart,
  // Sample
  input wire i_valid,
  input wire [`MSZ_W-1:0] i_value,
  // Results
  output reg [`MSZ_W-1:0] o_min,
  output reg [`MSZ_W-1:0] o_max,
  output reg [`MSZ_W-1:0] o_peak,
  output reg o_valid
);
  reg [`MSZ_CNT_W-1:0] cnt_r;
  reg [`MSZ_W-1:0] run_min_r;
  reg [`MSZ_W-1:0] run_max_r;
  reg first_r;
  wire [`MSZ_CNT_W-1:0] last_idx = ({{(`MSZ_CNT_W-1){1'b0}}, 1'b1} << i_depth_lg) -
    {{(`MSZ_CNT_W-1){1'b0}}, 1'b1};
  wire [`MSZ_W-1:0] nmin = (first_r || $signed(i_value) < $signed(run_min_r)) ?
    i_value : run_min_r;
  wire [`MSZ_W-1:0] nmax = (first_r || $signed(i_value) > $signed(run_max_r)) ?
    i_value : run_max_r;
  always @(posedge i_clock) begin
    if (!i_rst_b || !i_enable) begin
      cnt_r <= {`MSZ_CNT_W{1'b0}};
      run_min_r <= {`MSZ_W{1'b0}};
      run_max_r <= {`MSZ_W{1'b0}};
      first_r <= 1'b1;
      o_min <= {`MSZ_W{1'b0}};
      o_max <= {`MSZ_W{1'b0}};
      o_peak <= {`MSZ_W{1'b0}};
      o_valid <= 1'b0;
    end else if (i_restart) begin
      // RULE_05 restart from next sample
      cnt_r <= {`MSZ_CNT_W{1'b0}};
      first_r <= 1'b1;
      o_valid <= 1'b0;
    end else if (i_valid) begin
      run_min_r <= nmin;
      run_max_r <= nmax;
      first_r <= 1'b0;
      // RULE_03 unbounded tracks every sample
      if (i_unbounded) begin
        o_min <= nmin;
        o_max <= nmax;
        o_peak <= nmax - nmin;
        o_valid <= 1'b1;
      // RULE_02 window closes after depth samples
      end else if (cnt_r == last_idx) begin
        cnt_r <= {`MSZ_CNT_W{1'b0}};
        first_r <= 1'b1;
        // RULE_01 min, max and peak
        o_min <= nmin;
        o_max <= nmax;
        o_peak <= nmax - nmin;
        o_valid <= 1'b1;
      end else begin
        cnt_r <= cnt_r + {{(`MSZ_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

// file: testbench/msz_host.sv
// Host model driving register accesses over Avalon-MM
`timescale 1ns/100ps
module msz_host (
  // Clock
  input wire logic i_clock,
  // Avalon-MM master
  input wire logic i_waitrequest,
  output logic [7:0] o_address = 8'h00,
  output logic o_read = 1'b0,
  output logic o_write = 1'b0,
  output logic [31:0] o_writedata = 32'h0
);
  // No fixed latency assumed: holds until waitrequest is seen low
  task access(input bit w, input bit [7:0] a, input bit [31:0] d);
    @(posedge i_clock);
    o_address <= a;
    o_writedata <= d;
    o_read <= ~w;
    o_write <= w;
    do @(posedge i_clock); while (i_waitrequest !== 1'b0);
    o_read <= 1'b0;
    o_write <= 1'b0;
  endtask
endmodule

// file: testbench/msz_props_properties.sv
// Checker for the statistics and zeroing core ports
`timescale 1ns/100ps
`include "msz_defines.vh"
module msz_props (
  // Clock and reset
  input wire i_clock,
  input wire i_rst_b,
  // Avalon-MM slave
  input wire [7:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [31:0] o_avs_readdata,
  input wire o_avs_waitrequest,
  // Stream and pin
  input wire i_sample_valid,
  input wire [`MSZ_NSIG*`MSZ_W-1:0] i_sample_bus,
  input wire i_multifunction_input_one,
  // Results
  input wire [`MSZ_NSTAT*`MSZ_W-1:0] o_stat_min,
  input wire [`MSZ_NSTAT*`MSZ_W-1:0] o_stat_max,
  input wire [`MSZ_NSTAT*`MSZ_W-1:0] o_stat_peak,
  input wire [`MSZ_NSTAT-1:0] o_stat_valid,
  input wire [`MSZ_NZERO*`MSZ_W-1:0] o_zero_value,
  input wire [`MSZ_NZERO-1:0] o_zero_active
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  wire req = i_avs_read | i_avs_write;
  wire wdone = i_avs_write & ~o_avs_waitrequest;
  a_wait_first: assert property ($rose(req) |-> o_avs_waitrequest) else $error("no wait state");
  a_wait_one: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("wait state too long");
  a_wait_idle: assert property (!req |-> !o_avs_waitrequest) else $error("wait while idle");
  a_peak_diff: assert property (o_stat_valid[0] |->
    o_stat_peak[31:0] == o_stat_max[31:0] - o_stat_min[31:0]) else $error("peak not max-min");
  a_min_max: assert property (o_stat_valid[0] |->
    $signed(o_stat_min[31:0]) <= $signed(o_stat_max[31:0])) else $error("min above max");
  a_stat_hold: assert property (!i_sample_valid && !i_avs_write && !$past(i_avs_write)
    |=> $stable(o_stat_min)) else $error("stats moved without sample");
  a_zero_hold: assert property (!i_sample_valid |=> $stable(o_zero_value))
    else $error("zero output moved without sample");
  a_restart_clear: assert property (wdone && i_avs_address == 8'h04 && i_avs_writedata[31]
    && !i_sample_valid |=> ##1 o_stat_valid == 4'h0) else $error("restart left results");
  a_reset_all: assert property (wdone && i_avs_address == 8'h14
    && i_avs_writedata[18:16] == 3'b101 |=> o_zero_active == 10'h000) else $error("reset all failed");
  c_stat: cover property (o_stat_valid[1]);
  c_zero: cover property (o_zero_active[0] && o_zero_active[1]);
  c_pin: cover property ($rose(o_zero_active[0]) && !$past(i_avs_write));
endmodule
bind msz_core msz_props msz_props_i (.*);

// file: testbench/tb_top.sv
// Self-checking bench for the statistics and zeroing core
`timescale 1ns/100ps
`include "msz_defines.vh"
module tb_top;
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic sv = 1'b0;
  logic sv_d = 1'b0;
  logic pin = 1'b0;
  logic [255:0] sb = '0;
  logic [31:0] rq[$];
  logic [63:0] zq[$];
  logic [31:0] mn, mx, c, t;
  wire [7:0] adr;
  wire rd, wr, wt;
  wire [31:0] wd, rdata;
  wire [319:0] zv;
  wire [3:0] stv;
  wire [9:0] za;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  bit [31:0] seed = 32'hb09ee211;
  always #2 i_clock = ~i_clock;
  msz_host msz_host_i (.i_clock(i_clock), .i_waitrequest(wt), .o_address(adr),
    .o_read(rd), .o_write(wr), .o_writedata(wd));
  msz_core msz_core_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wt), .i_sample_valid(sv), .i_sample_bus(sb),
    .i_multifunction_input_one(pin), .o_stat_min(), .o_stat_max(), .o_stat_peak(),
    .o_stat_valid(stv), .o_zero_value(zv), .o_zero_active(za));
  function automatic bit [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(logic [63:0] g, logic [63:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task w(bit [7:0] a, bit [31:0] d);
    msz_host_i.access(1'b1, a, d);
  endtask
  task r(bit [7:0] a, logic [31:0] e);
    rq.push_back(e);
    msz_host_i.access(1'b0, a, 32'h0);
  endtask
  task smp();
    @(posedge i_clock);
    for (int k = 0; k < 8; k++) sb[32*k+:32] <= rnd();
    sv <= 1'b1;
    @(posedge i_clock);
    sv <= 1'b0;
  endtask
  // Min and max of signal k over n new samples
  task run(int n, int k);
    logic [31:0] v;
    for (int i = 0; i < n; i++) begin
      smp();
      v = sb[32*k+:32];
      if (i == 0 || $signed(v) < $signed(mn)) mn = v;
      if (i == 0 || $signed(v) > $signed(mx)) mx = v;
    end
  endtask
  task pulse();
    @(posedge i_clock);
    pin <= 1'b1;
    repeat (4) @(posedge i_clock);
    pin <= 1'b0;
    repeat (4) @(posedge i_clock);
  endtask
  task conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Results are judged where they appear, against notes queued by the driver
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
    sv_d <= sv;
    if (rd && wt === 1'b0) cmp({32'h0, rdata}, {32'h0, rq.pop_front()});
    if (sv_d && zq.size() > 0) cmp(zv[63:0], zq.pop_front());
  end
  initial begin
    repeat (8) @(posedge i_clock);
    i_rst_b <= 1'b1;
    r(8'h40, 32'h0);
    w(8'h00, 32'h0001_1000);
    run(5, 0);
    w(8'h24, 32'h0);
    r(8'h28, mn);
    r(8'h2C, mx);
    r(8'h30, mx - mn);
    w(8'h04, 32'h8000_0000);
    run(1, 0);
    r(8'h28, mn);
    r(8'h2C, mn);
    w(8'h00, 32'h0001_0111);
    run(2, 1);
    run(2, 1);
    w(8'h24, 32'h1);
    r(8'h28, mn);
    r(8'h2C, mx);
    r(8'h08, 32'h3);
    w(8'h00, 32'h0001_0E12);
    r(8'h20, 32'h1);
    w(8'h20, 32'h1);
    w(8'h00, 32'h0);
    r(8'h08, 32'h2);
    cmp(stv, 64'h2);
    $display("statistics test done");
    t = rnd() % 32'd2000000000;
    w(8'h0C, t);
    r(8'h0C, t);
    w(8'h10, 32'h20);
    w(8'h0C, 32'h0);
    w(8'h10, 32'h21);
    smp();
    zq.push_back({2{sb[95:64]}});
    c = sb[95:64];
    w(8'h14, 32'h0003_0000);
    smp();
    zq.push_back({sb[95:64] - c, sb[95:64] - c + t});
    r(8'h18, 32'h0003_0003);
    w(8'h14, 32'h0005_0000);
    r(8'h18, 32'h3);
    smp();
    zq.push_back({2{sb[95:64]}});
    w(8'h10, 32'h121);
    r(8'h18, 32'h1);
    w(8'h0C, `MSZ_TARGET_MAX);
    w(8'h10, 32'h21);
    r(8'h20, 32'h0);
    w(8'h0C, 32'h7FF8_9EC1);
    w(8'h10, 32'h29);
    r(8'h20, 32'h1);
    r(8'h18, 32'h3);
    $display("zeroing test done");
    w(8'h1C, 32'h1);
    pulse();
    r(8'h18, 32'h3);
    w(8'h1C, 32'h0001_0001);
    pulse();
    r(8'h18, 32'h0001_0003);
    cmp(za, 64'h1);
    $display("external trigger test done");
    repeat (4) @(posedge i_clock);
    conclude();
  end
endmodule
